// [rtl/fsib_top.sv]
// Interrupt block with four sources, flags, vectors and context stacks
`timescale 1ns/1ps
`default_nettype none
// Function
// - Four sources: pin rising edge, 12-bit timer, basic timer, serial.
// - Acknowledge suspends program and redirects fetch to source vector.
// - Vectors: serial 01H, basic 02H, 12-bit timer 03H, pin 04H.
// - Each source has pending flag, enable flag and vector generator.
// - Global enable gates all; stacks updated on acknowledge.
// - Pending set by peripheral request, cleared when acknowledged.
// - Writing 1 to a pending flag acts as a request.
// - Pending stays set until acknowledged or written 0.
// - Only the acknowledged source's flag clears.
// - Pending flags are readable for polling.
// - Register 3FH: bit0 pin flag, bit3 live level, bits 2:1 zero.
// - Level bit reads 0 for low pin, 1 for high pin.
// - Register 3EH: bit0 timer flag, other bits zero.
// - Register 3CH: bit0 serial flag, other bits zero.
// - Flags clear on power-on, CE reset and clock stop.
// - Acknowledge needs enable, pending and global enable set.
// - Enable register 2FH, one bit per source, cleared on resets.
// - Global clears on acknowledge; allow delayed one op; block immediate.
// - Context pushed on two-level stack, cleared, restored on return.
module fsib_top
  import fsib_pkg::*;
#(
  parameter int ASK_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Peripheral requests, one-cycle pulses except the pin level
  input wire logic pin_event_level,
  input wire logic timer12_req,
  input wire logic basic_tick_req,
  input wire logic serial_req,
  // CPU sequencer controls
  input wire fsib_cpu_ctl_t cpu_ctl,
  input wire fsib_pc_t pc_in,
  input wire fsib_ctx_t ctx_in,
  // Register file port
  input wire fsib_rf_req_t rf_req,
  output logic [3:0] rf_rdata,
  // Acknowledge and redirect
  output logic irq_pending,
  output logic ack_take,
  output logic redirect_valid,
  output fsib_pc_t vector,
  output logic ctx_clear,
  // Return path
  output logic ret_valid,
  output fsib_pc_t ret_pc,
  output fsib_ctx_t ret_ctx,
  // Status of the source with no register here, and the global enable
  output logic basic_tick_pending,
  output logic global_allow
);

  localparam int SPW = $clog2(ASK_DEPTH);

  typedef struct packed {
    logic [FSIB_NSRC-1:0] pend;
    logic [FSIB_NSRC-1:0] allow;
    logic gallow;
    logic ei_arm;
    logic pin_prev;
    logic [1:0] ctx_cnt;
    fsib_ctx_t [FSIB_CTX_LEVELS-1:0] ctx;
    logic [SPW-1:0] sp;
    fsib_pc_t [ASK_DEPTH-1:0] ask;
    logic [3:0] rdata;
    logic redirect;
    fsib_pc_t vec;
    logic clr;
    logic ret;
    fsib_pc_t rpc;
    fsib_ctx_t rctx;
  } fsib_state_t;

  fsib_state_t s_q;
  fsib_state_t s_d;

  // ***************************************
  // Request detection and selection
  // ***************************************
  logic [FSIB_NSRC-1:0] src_set;
  logic [FSIB_NSRC-1:0] ready;
  logic [FSIB_NSRC-1:0] sel_oh;
  logic take;
  logic soft_clear;
  fsib_pc_t sel_vec;

  always_comb begin
    src_set = '0;
    src_set[FSIB_SRC_PIN] = pin_event_level & ~s_q.pin_prev;
    src_set[FSIB_SRC_TIMER12] = timer12_req;
    src_set[FSIB_SRC_BASIC] = basic_tick_req;
    src_set[FSIB_SRC_SERIAL] = serial_req;
  end

  // Resets clear flags, enables and global enable; no request may be taken meanwhile
  assign soft_clear = cpu_ctl.ce_reset | cpu_ctl.clock_stop_op;
  assign ready = s_q.pend & s_q.allow;
  // Block-all masks the request in its own cycle
  assign irq_pending = s_q.gallow & ~cpu_ctl.block_all_op & (|ready);
  // Taken only at an instruction boundary, never beside a return
  assign take = irq_pending & cpu_ctl.instr_done & ~soft_clear &
                ~cpu_ctl.return_from_service_op & ~cpu_ctl.allow_all_op;
  assign ack_take = take;

  always_comb begin
    sel_oh = '0;
    sel_vec = FSIB_VEC_SERIAL;
    if (ready[FSIB_SRC_PIN]) begin
      sel_oh[FSIB_SRC_PIN] = 1'b1;
      sel_vec = FSIB_VEC_PIN;
    end else if (ready[FSIB_SRC_TIMER12]) begin
      sel_oh[FSIB_SRC_TIMER12] = 1'b1;
      sel_vec = FSIB_VEC_TIMER12;
    end else if (ready[FSIB_SRC_BASIC]) begin
      sel_oh[FSIB_SRC_BASIC] = 1'b1;
      sel_vec = FSIB_VEC_BASIC;
    end else if (ready[FSIB_SRC_SERIAL]) begin
      sel_oh[FSIB_SRC_SERIAL] = 1'b1;
      sel_vec = FSIB_VEC_SERIAL;
    end
  end

  // ***************************************
  // Next state
  // ***************************************
  logic [FSIB_NSRC-1:0] wr_one;
  logic [FSIB_NSRC-1:0] wr_zero;
  logic [SPW-1:0] sp_dec;

  always_comb begin
    wr_one = '0;
    wr_zero = '0;
    sp_dec = s_q.sp - 1'b1;
    s_d = s_q;
    s_d.pin_prev = pin_event_level;
    s_d.redirect = 1'b0;
    s_d.clr = 1'b0;
    s_d.ret = 1'b0;
    // Window path writes to the flag registers
    if (rf_req.wr) begin
      case (rf_req.addr)
        FSIB_ADR_PIN: begin
          wr_one[FSIB_SRC_PIN] = rf_req.wdata[FSIB_BIT_FLAG];
          wr_zero[FSIB_SRC_PIN] = ~rf_req.wdata[FSIB_BIT_FLAG];
        end
        FSIB_ADR_TIMER12: begin
          wr_one[FSIB_SRC_TIMER12] = rf_req.wdata[FSIB_BIT_FLAG];
          wr_zero[FSIB_SRC_TIMER12] = ~rf_req.wdata[FSIB_BIT_FLAG];
        end
        FSIB_ADR_SERIAL: begin
          wr_one[FSIB_SRC_SERIAL] = rf_req.wdata[FSIB_BIT_FLAG];
          wr_zero[FSIB_SRC_SERIAL] = ~rf_req.wdata[FSIB_BIT_FLAG];
        end
        FSIB_ADR_ALLOW: begin
          s_d.allow = rf_req.wdata;
        end
        default: begin
          s_d.allow = s_q.allow;
        end
      endcase
    end
    // A new request wins over a written 0 or an acknowledge in the same cycle
    s_d.pend = (s_q.pend & ~wr_zero & ~(take ? sel_oh : '0)) |
               src_set | wr_one;
    // Allow-all arms, and the next boundary makes it live
    if (cpu_ctl.allow_all_op) begin
      s_d.ei_arm = 1'b1;
    end else if (s_q.ei_arm && cpu_ctl.instr_done) begin
      s_d.ei_arm = 1'b0;
      s_d.gallow = 1'b1;
    end
    if (cpu_ctl.block_all_op) begin
      s_d.gallow = 1'b0;
      s_d.ei_arm = 1'b0;
    end
    if (take) begin
      s_d.gallow = 1'b0;
      s_d.ei_arm = 1'b0;
      s_d.redirect = 1'b1;
      s_d.vec = sel_vec;
      s_d.sp = sp_dec;
      s_d.ask[sp_dec] = pc_in;
      // Third level pushes the oldest context out
      s_d.ctx[1] = s_q.ctx[0];
      s_d.ctx[0] = ctx_in;
      s_d.clr = 1'b1;
      if (s_q.ctx_cnt != 2'(FSIB_CTX_LEVELS)) begin
        s_d.ctx_cnt = s_q.ctx_cnt + 2'd1;
      end
    end else if (cpu_ctl.return_from_service_op) begin
      s_d.ret = 1'b1;
      s_d.rpc = s_q.ask[s_q.sp];
      s_d.sp = s_q.sp + 1'b1;
      // Empty context stack hands back zeros
      s_d.rctx = (s_q.ctx_cnt != 2'd0) ? s_q.ctx[0] : '0;
      s_d.ctx[0] = s_q.ctx[1];
      s_d.ctx[1] = '0;
      if (s_q.ctx_cnt != 2'd0) begin
        s_d.ctx_cnt = s_q.ctx_cnt - 2'd1;
      end
    end
    // Registered read data, one cycle after the read strobe
    if (rf_req.rd) begin
      case (rf_req.addr)
        FSIB_ADR_PIN: begin
          s_d.rdata = FSIB_RST_NIB;
          s_d.rdata[FSIB_BIT_FLAG] = s_q.pend[FSIB_SRC_PIN];
          s_d.rdata[FSIB_BIT_LEVEL] = pin_event_level;
        end
        FSIB_ADR_TIMER12: begin
          s_d.rdata = FSIB_RST_NIB;
          s_d.rdata[FSIB_BIT_FLAG] = s_q.pend[FSIB_SRC_TIMER12];
        end
        FSIB_ADR_SERIAL: begin
          s_d.rdata = FSIB_RST_NIB;
          s_d.rdata[FSIB_BIT_FLAG] = s_q.pend[FSIB_SRC_SERIAL];
        end
        FSIB_ADR_ALLOW: begin
          s_d.rdata = s_q.allow;
        end
        default: begin
          s_d.rdata = FSIB_RST_NIB;
        end
      endcase
    end
    // CE reset and clock stop behave like power-on for flags
    if (soft_clear) begin
      s_d.pend = '0;
      s_d.allow = '0;
      s_d.gallow = 1'b0;
      s_d.ei_arm = 1'b0;
    end
  end

  // ***************************************
  // State register
  // ***************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rf_rdata = s_q.rdata;
  assign redirect_valid = s_q.redirect;
  assign vector = s_q.vec;
  assign ctx_clear = s_q.clr;
  assign ret_valid = s_q.ret;
  assign ret_pc = s_q.rpc;
  assign ret_ctx = s_q.rctx;
  assign basic_tick_pending = s_q.pend[FSIB_SRC_BASIC];
  assign global_allow = s_q.gallow;

  // ***************************************
  // Checks
  // ***************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_take;
    take;
  endsequence

  sequence s_redirect(logic [12:0] v);
    redirect_valid && vector == v;
  endsequence

  chk_vector_value: assert property (
    s_take |=> s_redirect($past(sel_vec)) ##1 !redirect_valid)
    else $error("wrong vector or redirect length");
  chk_pin_priority: assert property (
    take && ready[FSIB_SRC_PIN] |=> vector == FSIB_VEC_PIN)
    else $error("pin not served first");
  chk_ack_clears_own: assert property (
    take && !(|(src_set & sel_oh)) && !(|(wr_one & sel_oh))
    |=> !(|(s_q.pend & $past(sel_oh))))
    else $error("served flag not cleared");
  chk_others_kept: assert property (
    take && !soft_clear && !(|wr_zero)
    |=> (s_q.pend & $past(s_q.pend & ~sel_oh)) == $past(s_q.pend & ~sel_oh))
    else $error("unserved flag lost");
  chk_take_needs_all: assert property (
    take |-> s_q.gallow && (|(s_q.pend & s_q.allow)))
    else $error("taken without enables");
  chk_global_off: assert property (
    take || cpu_ctl.block_all_op |=> !global_allow)
    else $error("global enable still set");
  chk_allow_delayed: assert property (
    $rose(global_allow) |-> $past(s_q.ei_arm) && $past(cpu_ctl.instr_done))
    else $error("allow-all took effect early");
  chk_block_now: assert property (
    cpu_ctl.block_all_op |-> !irq_pending && !ack_take)
    else $error("block-all not immediate");
  chk_soft_reset: assert property (
    soft_clear |=> s_q.pend == '0 && s_q.allow == '0 && !global_allow)
    else $error("reset did not clear flags");
  chk_pin_edge: assert property (
    pin_event_level && !$past(pin_event_level) && !soft_clear
    |=> s_q.pend[FSIB_SRC_PIN])
    else $error("pin edge not latched");
  chk_write_one: assert property (
    rf_req.wr && rf_req.addr == FSIB_ADR_TIMER12 &&
    rf_req.wdata[FSIB_BIT_FLAG] && !soft_clear
    |=> s_q.pend[FSIB_SRC_TIMER12])
    else $error("soft request not set");
  chk_level_read: assert property (
    rf_req.rd && rf_req.addr == FSIB_ADR_PIN
    |=> rf_rdata[FSIB_BIT_LEVEL] == $past(pin_event_level) &&
        rf_rdata[2:1] == 2'b00)
    else $error("pin register read wrong");
  chk_ctx_push: assert property (
    s_take |=> ctx_clear && s_q.ctx[0] == $past(ctx_in) &&
               s_q.ask[s_q.sp] == $past(pc_in))
    else $error("context not saved");

  chk_ret_pop: assert property (
    cpu_ctl.return_from_service_op && !take
    |=> ret_valid && s_q.sp == $past(s_q.sp) + 1'b1)
    else $error("return did not pop");

  chk_sp_push: assert property (
    s_take |=> s_q.sp == $past(s_q.sp) - 1'b1)
    else $error("stack pointer not lowered");

  chk_basic_set: assert property (
    basic_tick_req && !soft_clear |=> basic_tick_pending)
    else $error("basic timer request lost");

  chk_write_zero: assert property (
    rf_req.wr && rf_req.addr == FSIB_ADR_TIMER12 &&
    !rf_req.wdata[FSIB_BIT_FLAG] && !timer12_req
    |=> !s_q.pend[FSIB_SRC_TIMER12])
    else $error("soft clear of flag ignored");

endmodule
`default_nettype wire

// [inc/fsib_pkg.sv]
// Package: constants and types of the four source interrupt block
package fsib_pkg;
  // ***************************************
  // Register file addresses
  // ***************************************
  localparam logic [6:0] FSIB_ADR_ALLOW = 7'h2f;
  localparam logic [6:0] FSIB_ADR_SERIAL = 7'h3c;
  localparam logic [6:0] FSIB_ADR_TIMER12 = 7'h3e;
  localparam logic [6:0] FSIB_ADR_PIN = 7'h3f;
  // ***************************************
  // Source index, also the enable bit position
  // ***************************************
  localparam int FSIB_SRC_PIN = 0;
  localparam int FSIB_SRC_TIMER12 = 1;
  localparam int FSIB_SRC_BASIC = 2;
  localparam int FSIB_SRC_SERIAL = 3;
  localparam int FSIB_NSRC = 4;
  // ***************************************
  // Field positions and reset values
  // ***************************************
  localparam int FSIB_BIT_FLAG = 0;
  localparam int FSIB_BIT_LEVEL = 3;
  localparam logic [3:0] FSIB_RST_NIB = 4'h0;
  localparam int FSIB_CTX_LEVELS = 2;
  // ***************************************
  // Vector addresses
  // ***************************************
  localparam logic [12:0] FSIB_VEC_SERIAL = 13'h0001;
  localparam logic [12:0] FSIB_VEC_BASIC = 13'h0002;
  localparam logic [12:0] FSIB_VEC_TIMER12 = 13'h0003;
  localparam logic [12:0] FSIB_VEC_PIN = 13'h0004;
  // ***************************************
  // Carried groups
  // ***************************************
  typedef logic [12:0] fsib_pc_t;
  typedef struct packed {
    logic [3:0] bank;
    logic [6:0] regptr;
    logic [3:0] status_word;
  } fsib_ctx_t;
  typedef struct packed {
    logic instr_done;
    logic allow_all_op;
    logic block_all_op;
    logic return_from_service_op;
    logic clock_stop_op;
    logic ce_reset;
  } fsib_cpu_ctl_t;
  typedef struct packed {
    logic rd;
    logic wr;
    logic [6:0] addr;
    logic [3:0] wdata;
  } fsib_rf_req_t;
endpackage

// [dv/fsib_src_model.sv]
// Peripheral request sources that face the interrupt block
`timescale 1ns/1ps
`default_nettype none
module fsib_src_model (
  // Clock
  input wire logic clk,
  // Bench commands
  input wire logic pin_cmd,
  input wire logic [3:1] fire,
  // Requests toward the block
  output logic pin_event_level,
  output logic timer12_req,
  output logic basic_tick_req,
  output logic serial_req
);
  // Registered so each request starts on a clean edge
  always_ff @(posedge clk) begin
    pin_event_level <= pin_cmd;
    timer12_req <= fire[1];
    basic_tick_req <= fire[2];
    serial_req <= fire[3];
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
// Self-checking bench of the four source interrupt block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import fsib_pkg::*;
;
  logic clk, rst, pin_cmd, pin_event_level, timer12_req, basic_tick_req;
  logic serial_req, irq_pending, ack_take, redirect_valid, ctx_clear;
  logic ret_valid, basic_tick_pending, global_allow, rd_seen;
  logic [3:0] fire, rf_rdata;
  logic [15:0] lfsr_q;
  logic [27:0] exp_q[$];
  logic [27:0] saved[4];
  fsib_cpu_ctl_t cpu_ctl;
  fsib_pc_t pc_in, vector, ret_pc;
  fsib_ctx_t ctx_in, ret_ctx;
  fsib_rf_req_t rf_req;
  int n_fail, checks_done, cycles, n_take;
  logic [6:0] adrs[5] = '{FSIB_ADR_ALLOW, FSIB_ADR_PIN, FSIB_ADR_TIMER12,
    FSIB_ADR_SERIAL, 7'h10};
  fsib_pc_t vecs[4] = '{FSIB_VEC_PIN, FSIB_VEC_TIMER12, FSIB_VEC_BASIC,
    FSIB_VEC_SERIAL};

  fsib_src_model u_src (.clk(clk), .pin_cmd(pin_cmd), .fire(fire[3:1]),
    .pin_event_level(pin_event_level), .timer12_req(timer12_req),
    .basic_tick_req(basic_tick_req), .serial_req(serial_req));
  fsib_top u_dut (.clk(clk), .rst(rst), .pin_event_level(pin_event_level),
    .timer12_req(timer12_req), .basic_tick_req(basic_tick_req),
    .serial_req(serial_req), .cpu_ctl(cpu_ctl), .pc_in(pc_in),
    .ctx_in(ctx_in), .rf_req(rf_req), .rf_rdata(rf_rdata),
    .irq_pending(irq_pending), .ack_take(ack_take),
    .redirect_valid(redirect_valid), .vector(vector),
    .ctx_clear(ctx_clear), .ret_valid(ret_valid), .ret_pc(ret_pc),
    .ret_ctx(ret_ctx), .basic_tick_pending(basic_tick_pending),
    .global_allow(global_allow));

  // ***************************************
  // Clock, checks and closing
  // ***************************************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic check(input logic [27:0] seen, input logic [27:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d failures %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic take_note(input logic [27:0] seen);
    logic [27:0] e;
    // Empty queue means nothing was due, so any result is a mismatch
    e = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
    check(seen, e);
  endtask
  always @(posedge clk) begin
    rd_seen <= rf_req.rd & ~rst;
    // Counts every accepted request, stray ones included
    if (ack_take) n_take++;
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  always @(negedge clk) begin
    if (rd_seen) take_note({24'h0, rf_rdata});
    if (redirect_valid) take_note({15'h0, vector});
    if (redirect_valid) check(28'(ctx_clear), 28'h1);
    if (ret_valid) take_note({ret_ctx, ret_pc});
  end

  // ***************************************
  // Drivers, all on the falling edge
  // ***************************************
  task automatic tick();
    @(negedge clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [3:0] d);
    rf_req = '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    tick();
    rf_req.wr = 1'b0;
    tick();
  endtask
  task automatic rd(input logic [6:0] a, input logic [3:0] e);
    exp_q.push_back({24'h0, e});
    rf_req = '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 4'h0};
    tick();
    rf_req.rd = 1'b0;
    tick();
  endtask
  // Bits: done, allow-all, block-all, return, clock stop, CE reset
  task automatic pulse(input logic [5:0] c);
    cpu_ctl = fsib_cpu_ctl_t'(c);
    tick();
    cpu_ctl = '0;
    tick();
  endtask
  task automatic fire_src(input logic [3:0] f);
    fire = f;
    tick();
    fire = 4'h0;
    tick();
  endtask
  task automatic ack(input fsib_pc_t v, input int k);
    lfsr_q = lfsr_next(lfsr_q);
    pc_in = lfsr_q[12:0];
    ctx_in = {lfsr_q[3:0], lfsr_q[15:9], lfsr_q[7:4]};
    saved[k] = {ctx_in, pc_in};
    exp_q.push_back({15'h0, v});
    pulse(6'h20);
  endtask

  initial begin
    rst = 1'b1;
    pin_cmd = 1'b0;
    fire = 4'h0;
    cpu_ctl = '0;
    pc_in = '0;
    ctx_in = '0;
    rf_req = '0;
    lfsr_q = 16'h11ef;
    repeat (3) @(posedge clk);
    @(negedge clk) rst = 1'b0;
    foreach (adrs[i]) rd(adrs[i], 4'h0);
    wr(FSIB_ADR_ALLOW, 4'hf);
    rd(FSIB_ADR_ALLOW, 4'hf);
    wr(FSIB_ADR_PIN, 4'he);
    rd(FSIB_ADR_PIN, 4'h0);
    wr(FSIB_ADR_TIMER12, 4'h1);
    rd(FSIB_ADR_TIMER12, 4'h1);
    wr(FSIB_ADR_TIMER12, 4'h0);
    rd(FSIB_ADR_TIMER12, 4'h0);
    pin_cmd = 1'b1;
    fire_src(4'he);
    rd(FSIB_ADR_PIN, 4'h9);
    rd(FSIB_ADR_SERIAL, 4'h1);
    for (int i = 0; i < 4; i++) begin
      pulse(6'h10);
      pulse(6'h20);
      check(28'(global_allow), 28'h1);
      check(28'(irq_pending), 28'h1);
      ack(vecs[i], i);
      check(28'(global_allow), 28'h0);
      rd(FSIB_ADR_TIMER12, {3'h0, i < 1});
      rd(FSIB_ADR_SERIAL, {3'h0, i < 3});
      check(28'(basic_tick_pending), 28'(i < 2));
    end
    // Two context levels only: the two oldest come back as zero
    for (int k = 3; k >= 0; k--) begin
      exp_q.push_back({k >= 2 ? saved[k][27:13] : 15'h0, saved[k][12:0]});
      pulse(6'h04);
    end
    wr(FSIB_ADR_ALLOW, 4'h0);
    fire_src(4'h2);
    pulse(6'h10);
    pulse(6'h20);
    pulse(6'h20);
    check(28'(irq_pending), 28'h0);
    wr(FSIB_ADR_ALLOW, 4'h2);
    pulse(6'h28);
    check(28'(global_allow), 28'h0);
    pulse(6'h20);
    pulse(6'h02);
    rd(FSIB_ADR_TIMER12, 4'h0);
    rd(FSIB_ADR_ALLOW, 4'h0);
    wr(FSIB_ADR_ALLOW, 4'hf);
    pulse(6'h01);
    rd(FSIB_ADR_ALLOW, 4'h0);
    repeat (2) tick();
    check(28'(n_take), 28'h4);
    check(28'(exp_q.size()), 28'h0);
    stop_test();
  end
endmodule
`default_nettype wire
